// ### verilog/vih_vectored_interrupt_handler.sv
`timescale 1ns/1ps
// Overview of operation
// - a valid source condition sets that source's pending flag to one
// - pending flags set regardless of any enable state
// - request only when global enable, source enable and pending all set
// - accepted request issues long call to source vector after current instruction
// - routines end with return-from-interrupt, resuming the interrupted program
// - with interrupts disabled, pending flags are ignored for vectoring
// - some sources clear their pending flag automatically on vectoring
// - flag still set after return re-enters at the end of the second instruction after the return
// - each source has its own enable bit in the enable register
// - source enables count only while global enable is one
// - global enable zero blocks every source
// - requests arriving while globally disabled stay pending until enabled
// - software writing one to a pending flag acts like hardware event
// - software-set flag vectors to that flag's own routine address
// - two priority levels; high preempts low, high never preempted
// - simultaneous requests: higher level first, ties by fixed source order
// - pending flags sampled and priority decoded every clock cycle
module vih_vectored_interrupt_handler
    import vih_pkg::*;
(
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [NSRC-1:0] srcEvent,
    input wire logic [1:0] extIntPin,
    input wire logic instrEnd,
    input wire logic retiDone,
    output logic irqReq,
    output logic callStrobe,
    output vih_call_t callInfo
);

    // ****************************************************************
    // state
    // ****************************************************************
    logic globalIrqEnable;
    logic [NSRC-1:0] enable;
    logic [NSRC-1:0] priority_;
    logic [NSRC-1:0] pending;
    logic levelHigh;
    logic levelLow;
    logic holdOff;
    logic reqValid;
    logic [1:0] extSync1;
    logic [1:0] extSync2;
    logic [1:0] extPrev;
    logic [NSRC-1:0] hwSet;
    logic [NSRC-1:0] swSet;
    logic [NSRC-1:0] swClr;
    logic [NSRC-1:0] autoClr;
    logic [NSRC-1:0] eligible;
    logic [NSRC-1:0] eligHigh;
    logic [NSRC-1:0] eligLow;
    logic allowHigh;
    logic allowLow;
    logic next_reqValid;
    logic next_winHigh;
    logic [SRC_W-1:0] next_winSrc;
    logic winAllowed;
    logic wrAccess;
    logic setupPhase;
    logic [31:0] next_prdata;
    logic next_pslverr;
    logic [31:0] statusWord;

    function automatic logic [SRC_W-1:0] vih_first_set(input logic [NSRC-1:0] v);
        logic [SRC_W-1:0] r;
        r = '0;
        // lowest source index wins a tie
        for (int i = NSRC - 1; i >= 0; i--)
        begin
            if (v[i])
                r = SRC_W'(i);
        end
        return r;
    endfunction : vih_first_set

    // ****************************************************************
    // external pins
    // ****************************************************************
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            extSync1 <= 2'h0;
            extSync2 <= 2'h0;
            extPrev <= 2'h0;
        end
        else
        begin
            extSync1 <= extIntPin;
            extSync2 <= extSync1;
            extPrev <= extSync2;
        end
    end

    // rising edge of a synchronised pin is the valid condition
    always_comb
    begin
        hwSet = srcEvent;
        hwSet[EXT0_SRC] = srcEvent[EXT0_SRC] | (extSync2[0] & ~extPrev[0]);
        hwSet[EXT1_SRC] = srcEvent[EXT1_SRC] | (extSync2[1] & ~extPrev[1]);
    end

    // ****************************************************************
    // APB slave
    // ****************************************************************
    assign setupPhase = psel & ~penable;
    assign wrAccess = psel & penable & pwrite;
    assign pready = psel & penable;
    assign swSet = (wrAccess && paddr == OFS_PEND_SET) ? pwdata[NSRC-1:0] : '0;
    assign swClr = (wrAccess && paddr == OFS_PEND_CLR) ? pwdata[NSRC-1:0] : '0;

    always_comb
    begin
        statusWord = '0;
        statusWord[ST_SRC_LSB +: SRC_W] = callInfo.src;
        statusWord[ST_WIN_HIGH_BIT] = callInfo.high;
        statusWord[ST_REQ_BIT] = reqValid;
        statusWord[ST_LVL_HIGH_BIT] = levelHigh;
        statusWord[ST_LVL_LOW_BIT] = levelLow;
        statusWord[ST_HOLD_BIT] = holdOff;
    end

    always_comb
    begin
        next_prdata = '0;
        next_pslverr = 1'b0;
        unique case (paddr)
            OFS_CTRL: next_prdata[CTRL_GIE_BIT] = globalIrqEnable;
            OFS_ENABLE: next_prdata[NSRC-1:0] = enable;
            OFS_PRIORITY: next_prdata[NSRC-1:0] = priority_;
            OFS_PEND_SET: next_prdata[NSRC-1:0] = pending;
            OFS_PEND_CLR: next_prdata = '0;
            OFS_STATUS: next_prdata = statusWord;
            default: next_pslverr = 1'b1;
        endcase
    end

    // answer is staged in the setup cycle so that read data comes from flops
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            prdata <= '0;
            pslverr <= 1'b0;
        end
        else if (setupPhase)
        begin
            prdata <= pwrite ? 32'h0000_0000 : next_prdata;
            pslverr <= next_pslverr;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            globalIrqEnable <= 1'b0;
            enable <= RST_ENABLE;
            priority_ <= RST_PRIORITY;
        end
        else if (wrAccess)
        begin
            if (paddr == OFS_CTRL)
                globalIrqEnable <= pwdata[CTRL_GIE_BIT];
            if (paddr == OFS_ENABLE)
                enable <= pwdata[NSRC-1:0];
            if (paddr == OFS_PRIORITY)
                priority_ <= pwdata[NSRC-1:0];
        end
    end

    // ****************************************************************
    // pending flags
    // ****************************************************************
    assign autoClr = callStrobe ? (AUTO_CLEAR_MASK & (NSRC'(1) << callInfo.src)) : '0;

    // a set in the same cycle as a clear wins, so no event is lost
    for (genvar i = 0; i < NSRC; i++)
    begin : g_pend
        always_ff @(posedge mclk)
        begin
            if (sys_rst)
                pending[i] <= RST_PENDING[i];
            else if (hwSet[i] | swSet[i])
                pending[i] <= 1'b1;
            else if (swClr[i] | autoClr[i])
                pending[i] <= 1'b0;
        end
    end

    // ****************************************************************
    // recognition and priority decode
    // ****************************************************************
    // global gate masks everything; flags simply wait while it is low
    assign eligible = pending & enable & {NSRC{globalIrqEnable}};
    assign eligHigh = eligible & priority_;
    assign eligLow = eligible & ~priority_;
    assign allowHigh = ~levelHigh;
    assign allowLow = ~levelHigh & ~levelLow;

    always_comb
    begin
        next_reqValid = 1'b0;
        next_winHigh = 1'b0;
        next_winSrc = '0;
        if (allowHigh && |eligHigh)
        begin
            next_reqValid = 1'b1;
            next_winHigh = 1'b1;
            next_winSrc = vih_first_set(eligHigh);
        end
        else if (allowLow && |eligLow)
        begin
            next_reqValid = 1'b1;
            next_winSrc = vih_first_set(eligLow);
        end
    end

    // decode is registered each cycle: one cycle to detect
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            reqValid <= 1'b0;
            callInfo <= '0;
        end
        else
        begin
            reqValid <= next_reqValid;
            callInfo.high <= next_winHigh;
            callInfo.src <= next_winSrc;
            callInfo.vector <= VEC_BASE + 16'(VEC_STEP * 16'(next_winSrc));
        end
    end

    assign irqReq = reqValid;

    // ****************************************************************
    // call and return
    // ****************************************************************
    // recheck live state so a flag cleared or a gate closed a cycle ago is not taken
    assign winAllowed = eligible[callInfo.src] & (callInfo.high ? allowHigh : allowLow);
    assign callStrobe = instrEnd & reqValid & ~holdOff & winAllowed;

    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            levelHigh <= 1'b0;
            levelLow <= 1'b0;
        end
        else if (callStrobe)
        begin
            if (callInfo.high)
                levelHigh <= 1'b1;
            else
                levelLow <= 1'b1;
        end
        else if (retiDone)
        begin
            // return closes the innermost active level
            if (levelHigh)
                levelHigh <= 1'b0;
            else
                levelLow <= 1'b0;
        end
    end

    // one instruction must complete after a return before the next call
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
            holdOff <= 1'b0;
        else if (retiDone)
            holdOff <= 1'b1;
        else if (instrEnd)
            holdOff <= 1'b0;
    end

    // ****************************************************************
    // checks
    // ****************************************************************
    a_pend_set: assert property (@(posedge mclk) disable iff (sys_rst)
        (hwSet != '0) |=> ((pending & $past(hwSet)) == $past(hwSet)))
        else $error("hardware event did not set pending flag");

    a_sw_set: assert property (@(posedge mclk) disable iff (sys_rst)
        (swSet != '0) |=> ((pending & $past(swSet)) == $past(swSet)))
        else $error("software set of pending flag lost");

    a_call_gate: assert property (@(posedge mclk) disable iff (sys_rst)
        callStrobe |-> (globalIrqEnable && enable[callInfo.src] && pending[callInfo.src]))
        else $error("call issued without enables and pending");

    a_global_off: assert property (@(posedge mclk) disable iff (sys_rst)
        !globalIrqEnable |-> !callStrobe && !next_reqValid)
        else $error("request while globally disabled");

    a_hold_pend: assert property (@(posedge mclk) disable iff (sys_rst)
        (!globalIrqEnable && swClr == '0)
        |=> ((pending & $past(pending)) == $past(pending)))
        else $error("pending flag lost while masked");

    a_auto_clear: assert property (@(posedge mclk) disable iff (sys_rst)
        (callStrobe && AUTO_CLEAR_MASK[callInfo.src] && !hwSet[callInfo.src]
        && !swSet[callInfo.src]) |=> !pending[$past(callInfo.src)])
        else $error("auto clear flag not cleared on vectoring");

    a_vector_map: assert property (@(posedge mclk) disable iff (sys_rst)
        callStrobe |-> callInfo.vector == VEC_BASE + 16'(VEC_STEP * 16'(callInfo.src)))
        else $error("wrong vector address");

    a_return_from_interrupt_gap: assert property (@(posedge mclk) disable iff (sys_rst)
        retiDone |=> holdOff && !callStrobe)
        else $error("call issued right after return");

    a_high_block: assert property (@(posedge mclk) disable iff (sys_rst)
        (levelHigh || (levelLow && !callInfo.high)) |-> !callStrobe)
        else $error("preemption rule broken");

    a_prio_order: assert property (@(posedge mclk) disable iff (sys_rst)
        (reqValid && !callInfo.high) |-> !($past(eligHigh) != '0 && $past(allowHigh)))
        else $error("low level chosen over high");

    a_decode_each: assert property (@(posedge mclk) disable iff (sys_rst)
        next_reqValid |=> reqValid && callInfo.src == $past(next_winSrc))
        else $error("decode not registered this cycle");

    // checked on the release edge only; before the first reset edge the flops hold nothing
    a_reset_en: assert property (@(posedge mclk)
        $fell(sys_rst) |-> !globalIrqEnable && enable == '0)
        else $error("enables not zero after reset");

endmodule : vih_vectored_interrupt_handler

// ### verilog/vih_pkg.sv
package vih_pkg;

    // ****************************************************************
    // source map
    // ****************************************************************
    localparam int NSRC = 19;
    localparam int SRC_W = 5;
    localparam int EXT0_SRC = 0;
    localparam int EXT1_SRC = 2;
    // external interrupts 0/1 and timers 0/1 are cleared on vectoring
    localparam logic [NSRC-1:0] AUTO_CLEAR_MASK = 19'h0000F;
    localparam logic [15:0] VEC_BASE = 16'h0003;
    localparam logic [15:0] VEC_STEP = 16'h0008;

    // ****************************************************************
    // register map
    // ****************************************************************
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_ENABLE = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_PRIORITY = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_PEND_SET = 8'h0C;
    localparam logic [ADDR_W-1:0] OFS_PEND_CLR = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h14;
    localparam int CTRL_GIE_BIT = 0;
    localparam int ST_SRC_LSB = 0;
    localparam int ST_WIN_HIGH_BIT = 5;
    localparam int ST_REQ_BIT = 6;
    localparam int ST_LVL_HIGH_BIT = 7;
    localparam int ST_LVL_LOW_BIT = 8;
    localparam int ST_HOLD_BIT = 9;
    localparam logic [NSRC-1:0] RST_ENABLE = 19'h00000;
    localparam logic [NSRC-1:0] RST_PRIORITY = 19'h00000;
    localparam logic [NSRC-1:0] RST_PENDING = 19'h00000;

    // ****************************************************************
    // carriers
    // ****************************************************************
    typedef struct packed {
        logic high;
        logic [SRC_W-1:0] src;
        logic [15:0] vector;
    } vih_call_t;

endpackage : vih_pkg

// ### testbench/vih_core_model.sv
`timescale 1ns/1ps
// ********
// core stand-in: retires instructions, takes calls, returns on command
// ********
module vih_core_model
    import vih_pkg::*;
(
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic [3:0] instrGap,
    input wire logic doReti,
    input wire logic callStrobe,
    input wire vih_call_t callInfo,
    output logic instrEnd,
    output logic retiDone,
    output logic [15:0] lastVector,
    output logic [7:0] callCount
);
    logic [3:0] gapCnt;
    // the return instruction itself never reports instrEnd
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            gapCnt <= 4'h0;
            instrEnd <= 1'b0;
            retiDone <= 1'b0;
        end
        else if (doReti)
        begin
            retiDone <= 1'b1;
            instrEnd <= 1'b0;
            gapCnt <= instrGap;
        end
        else
        begin
            retiDone <= 1'b0;
            instrEnd <= (gapCnt == 4'h0);
            gapCnt <= (gapCnt == 4'h0) ? instrGap : gapCnt - 4'h1;
        end
    end
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            lastVector <= 16'h0000;
            callCount <= 8'h00;
        end
        else if (callStrobe)
        begin
            lastVector <= callInfo.vector;
            callCount <= callCount + 8'h01;
        end
    end
endmodule : vih_core_model

// ### testbench/tb_top.sv
`timescale 1ns/1ps
module tb_top
    import vih_pkg::*;
;
    logic mclk = 1'b0, sys_rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [ADDR_W-1:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, instrEnd, retiDone, irqReq, callStrobe, doReti = 1'b0, er;
    logic [NSRC-1:0] srcEvent = 19'h00000;
    logic [1:0] extIntPin = 2'h0;
    logic [15:0] lastVector;
    logic [7:0] callCount;
    vih_call_t callInfo;
    int err_count = 0, samples_checked = 0, cycles = 0;
    always #5 mclk = ~mclk;
    vih_vectored_interrupt_handler dut (.mclk(mclk), .sys_rst(sys_rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .srcEvent(srcEvent), .extIntPin(extIntPin),
        .instrEnd(instrEnd), .retiDone(retiDone), .irqReq(irqReq), .callStrobe(callStrobe),
        .callInfo(callInfo));
    vih_core_model core (.mclk(mclk), .sys_rst(sys_rst), .instrGap(4'h2), .doReti(doReti),
        .callStrobe(callStrobe), .callInfo(callInfo), .instrEnd(instrEnd),
        .retiDone(retiDone), .lastVector(lastVector), .callCount(callCount));
    // ********
    // helpers
    // ********
    task automatic close_out();
        $display("checks %0d errors %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : close_out
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            err_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    // one aligned word; released only after pready is seen high at an edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do @(posedge mclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk);
    endtask : apb
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(rd, exp);
    endtask : rd_chk
    task automatic return_from_interrupt();
        doReti <= 1'b1;
        @(posedge mclk);
        doReti <= 1'b0;
        @(posedge mclk);
    endtask : return_from_interrupt
    task automatic wait_call(input logic [15:0] vec);
        logic [7:0] c;
        int n;
        c = callCount;
        n = 0;
        while (callCount === c && n < 200)
        begin
            @(posedge mclk);
            n++;
        end
        check({24'h0, callCount}, {24'h0, c + 8'h01});
        check({16'h0, lastVector}, {16'h0, vec});
    endtask : wait_call
    task automatic no_call(input int n);
        logic [7:0] c;
        c = callCount;
        repeat (n) @(posedge mclk);
        check({24'h0, callCount}, {24'h0, c});
    endtask : no_call
    always @(posedge mclk)
    begin
        cycles++;
        if (cycles >= 6000)
        begin
            err_count++;
            close_out();
        end
    end
    // ********
    // tests
    // ********
    initial
    begin
        repeat (10) @(posedge mclk);
        sys_rst <= 1'b0;
        @(posedge mclk);
        rd_chk(OFS_CTRL, 32'h0);
        rd_chk(OFS_ENABLE, 32'h0);
        rd_chk(OFS_PRIORITY, 32'h0);
        rd_chk(OFS_PEND_SET, 32'h0);
        rd_chk(8'h18, 32'h0);
        check({31'h0, er}, 32'h1);
        apb(1'b1, OFS_ENABLE, 32'h1F2);
        apb(1'b1, OFS_PRIORITY, 32'h140);
        srcEvent <= 19'h00020;
        extIntPin <= 2'h3;
        @(posedge mclk);
        srcEvent <= 19'h00000;
        repeat (6) @(posedge mclk);
        rd_chk(OFS_PEND_SET, 32'h25);
        no_call(20);
        check({31'h0, irqReq}, 32'h0);
        apb(1'b1, OFS_PEND_CLR, 32'h5);
        apb(1'b1, OFS_CTRL, 32'h1);
        wait_call(16'h002B);
        rd_chk(OFS_PEND_SET, 32'h20);
        return_from_interrupt();
        wait_call(16'h002B);
        apb(1'b1, OFS_PEND_CLR, 32'h20);
        return_from_interrupt();
        no_call(20);
        apb(1'b1, OFS_PEND_SET, 32'h2);
        wait_call(16'h000B);
        rd_chk(OFS_PEND_SET, 32'h0);
        return_from_interrupt();
        // high and low at once: high first, low waits for its return
        apb(1'b1, OFS_PEND_SET, 32'h50);
        wait_call(16'h0033);
        rd_chk(OFS_STATUS, 32'h80);
        no_call(20);
        apb(1'b1, OFS_PEND_CLR, 32'h40);
        return_from_interrupt();
        wait_call(16'h0023);
        apb(1'b1, OFS_PEND_SET, 32'h100);
        wait_call(16'h0043);
        rd_chk(OFS_STATUS, 32'h180);
        apb(1'b1, OFS_PEND_SET, 32'h40);
        no_call(20);
        apb(1'b1, OFS_PEND_CLR, 32'h150);
        return_from_interrupt();
        no_call(10);
        return_from_interrupt();
        apb(1'b1, OFS_PEND_SET, 32'hA0);
        wait_call(16'h002B);
        apb(1'b1, OFS_PEND_CLR, 32'hA0);
        return_from_interrupt();
        apb(1'b1, OFS_CTRL, 32'h0);
        apb(1'b1, OFS_PEND_SET, 32'h20);
        no_call(20);
        apb(1'b1, OFS_PEND_CLR, 32'h20);
        close_out();
    end
endmodule : tb_top
